// file: hw/cxe_defs.vh
// Constants for the exception entry block
`ifndef CXE_DEFS_VH
`define CXE_DEFS_VH
`define CXE_VEC_W       6
`define CXE_VEC_RESET   6'h00
`define CXE_VEC_NMI     6'h07
`define CXE_VEC_TRAP0   6'h08
`define CXE_VEC_BREAK   6'h0C
`define CXE_VEC_IRQ0    6'h0E
`define CXE_NIRQ        16
`define CXE_IRQ_W       4
`define CXE_VTAB_DEPTH  16
`define CXE_RST_SEQ     3'h4
`endif

// file: hw/cxe_vec_rom.v
// Vector number table for maskable sources, registered read
`timescale 1ns/10ps
`include "cxe_defs.vh"
module cxe_vec_rom (
  input  wire                  clk,
  input  wire [`CXE_IRQ_W-1:0] addr,
  output reg  [`CXE_VEC_W-1:0] data
);
  wire [`CXE_VEC_W-1:0] mem [0:`CXE_VTAB_DEPTH-1];
  genvar g;

  // Source index to vector number, fixed contents
  generate
    for (g = 0; g < `CXE_VTAB_DEPTH; g = g + 1) begin : gTab
      localparam [`CXE_VEC_W-1:0] IDX = g;
      assign mem[g] = `CXE_VEC_IRQ0 + IDX;
    end
  endgenerate

  // Registered read
  always @(posedge clk) begin
    data <= mem[addr];
  end
endmodule

// file: hw/cxe_exception_entry.v
// Exception entry: reset, trap, NMI, break and maskable interrupts
`timescale 1ns/10ps
`include "cxe_defs.vh"
module cxe_exception_entry (
  input  wire                  clk,
  input  wire                  rstn,
  input  wire                  extResetPinN,
  input  wire                  wdtOverflow,
  input  wire                  trapExec,
  input  wire [1:0]            trapNum,
  input  wire                  nmiReq,
  input  wire                  breakReq,
  input  wire [`CXE_NIRQ-1:0]  irqReq,
  input  wire                  intMask,
  input  wire                  boundary,
  input  wire                  excAck,
  output reg                   coreReset,
  output reg                   excStart,
  output reg  [`CXE_VEC_W-1:0] excVector,
  output reg                   excIsReset,
  output reg                   excBusy,
  output reg  [`CXE_NIRQ-1:0]  irqAccept
);
  // Sequencer states
  localparam ST_IDLE  = 2'h0;
  localparam ST_RHOLD = 2'h1;
  localparam ST_RSEQ  = 2'h2;
  localparam ST_ROM   = 2'h3;

  // Registers and internal nets
  reg [1:0]            state_r;
  reg [1:0]            state_nxt;
  reg                  pinSync1_r;
  reg                  pinSync2_r;
  reg                  wdtSync1_r;
  reg                  wdtSync2_r;
  reg [2:0]            seqCnt_r;
  reg [`CXE_IRQ_W-1:0] romAddr_r;
  wire [`CXE_VEC_W-1:0] romData;
  wire                 resetAsserted;
  wire [`CXE_NIRQ-1:0] irqLive;
  wire                 anyIrq;
  reg  [`CXE_IRQ_W-1:0] irqIdx;
  wire [`CXE_NIRQ-1:0] acceptHot;
  genvar g;

  // Lowest index wins among maskable sources
  function [`CXE_IRQ_W-1:0] prioEnc;
    input [`CXE_NIRQ-1:0] req;
    integer j;
    begin
      prioEnc = {`CXE_IRQ_W{1'b0}};
      for (j = `CXE_NIRQ - 1; j >= 0; j = j - 1) begin
        if (req[j]) begin
          prioEnc = j[`CXE_IRQ_W-1:0];
        end
      end
    end
  endfunction

  // Pin and watchdog synchronisers
  always @(posedge clk) begin
    if (!rstn) begin
      pinSync1_r <= 1'b0;
      pinSync2_r <= 1'b0;
      wdtSync1_r <= 1'b0;
      wdtSync2_r <= 1'b0;
    end else begin
      pinSync1_r <= extResetPinN;
      pinSync2_r <= pinSync1_r;
      wdtSync1_r <= wdtOverflow;
      wdtSync2_r <= wdtSync1_r;
    end
  end

  assign resetAsserted = !pinSync2_r || wdtSync2_r;

  assign irqLive = intMask ? {`CXE_NIRQ{1'b0}} : irqReq;
  assign anyIrq  = |irqLive;

  always @* begin
    irqIdx = prioEnc(irqLive);
  end

  // Vector table lookup, addressed by the live pick so that the
  // word is ready in the cycle after the index is latched
  cxe_vec_rom uRom (
    .clk  (clk),
    .addr (irqIdx),
    .data (romData)
  );

  // One-hot accept strobe from the latched index
  generate
    for (g = 0; g < `CXE_NIRQ; g = g + 1) begin : gHot
      localparam [`CXE_IRQ_W-1:0] IDX = g;
      assign acceptHot[g] = (romAddr_r == IDX);
    end
  endgenerate

  // Next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      // Irq goes to lookup only when nothing stronger waits
      ST_IDLE: begin
        if (resetAsserted) begin
          state_nxt = ST_RHOLD;
        end else if (boundary && !excBusy && anyIrq && !nmiReq &&
                     !breakReq && !trapExec) begin
          state_nxt = ST_ROM;
        end
      end
      ST_RHOLD: begin
        if (!resetAsserted) begin
          state_nxt = ST_RSEQ;
        end
      end
      ST_RSEQ: begin
        if (resetAsserted) begin
          state_nxt = ST_RHOLD;
        end else if (seqCnt_r == `CXE_RST_SEQ) begin
          state_nxt = ST_IDLE;
        end
      end
      // Vector word lands here, then back to idle
      ST_ROM: begin
        state_nxt = resetAsserted ? ST_RHOLD : ST_IDLE;
      end
      default: state_nxt = ST_RHOLD;
    endcase
  end

  // Sequencer and outputs; reset dominates every branch
  // Entry pulse and accept strobe last one cycle
  always @(posedge clk) begin
    if (!rstn) begin
      state_r    <= ST_RHOLD;
      seqCnt_r   <= 3'h0;
      romAddr_r  <= {`CXE_IRQ_W{1'b0}};
      coreReset  <= 1'b1;
      excStart   <= 1'b0;
      excVector  <= `CXE_VEC_RESET;
      excIsReset <= 1'b0;
      excBusy    <= 1'b0;
      irqAccept  <= {`CXE_NIRQ{1'b0}};
    end else begin
      state_r   <= state_nxt;
      excStart  <= 1'b0;
      irqAccept <= {`CXE_NIRQ{1'b0}};
      // Core has fetched the vector
      if (excAck) begin
        excBusy <= 1'b0;
      end
      if (resetAsserted) begin
        coreReset  <= 1'b1;
        excBusy    <= 1'b0;
        excIsReset <= 1'b0;
        seqCnt_r   <= 3'h0;
      end else if (state_r == ST_RHOLD) begin
        coreReset  <= 1'b0;
        seqCnt_r   <= 3'h0;
      end else if (state_r == ST_RSEQ) begin
        // Fixed delay before the reset entry pulse
        seqCnt_r <= seqCnt_r + 3'h1;
        if (seqCnt_r == `CXE_RST_SEQ) begin
          excStart   <= 1'b1;
          excVector  <= `CXE_VEC_RESET;
          excIsReset <= 1'b1;
          excBusy    <= 1'b1;
        end
      end else if (state_r == ST_ROM) begin
        excStart   <= 1'b1;
        excVector  <= romData;
        excIsReset <= 1'b0;
        excBusy    <= 1'b1;
        irqAccept  <= acceptHot;
      end else if (boundary && !excBusy) begin
        excIsReset <= 1'b0;
        if (nmiReq) begin
          excStart  <= 1'b1;
          excVector <= `CXE_VEC_NMI;
          excBusy   <= 1'b1;
        end else if (trapExec) begin
          excStart  <= 1'b1;
          excVector <= `CXE_VEC_TRAP0 + {4'h0, trapNum};
          excBusy   <= 1'b1;
        end else if (breakReq) begin
          excStart  <= 1'b1;
          excVector <= `CXE_VEC_BREAK;
          excBusy   <= 1'b1;
        end else if (anyIrq) begin
          romAddr_r <= irqIdx;
        end
      end
    end
  end
endmodule

// file: sim/cxe_core_model.sv
// Core model: boundary pulses and vector fetch ack
`timescale 1ns/10ps
module cxe_core_model (
  input  logic clk,
  input  logic rstn,
  input  logic coreReset,
  input  logic excStart,
  input  logic excIsReset,
  input  logic excBusy,
  output logic boundary,
  output logic excAck
);
  logic       run_r;
  logic [1:0] cnt_r;
  // Idle until reset entry, then a boundary every 4 cycles while excBusy is low
  always @(posedge clk) begin
    cnt_r    <= cnt_r + 2'h1;
    boundary <= run_r && !excBusy && cnt_r == 2'h0;
    excAck   <= excBusy && cnt_r == 2'h2;
    if (excStart && excIsReset) run_r <= 1'h1;
    if (!rstn || coreReset) begin
      {run_r, cnt_r, boundary, excAck} <= 5'h0;
    end
  end
endmodule

// file: sim/cxe_exception_entry_chk.sv
// Port assertions for the exception entry block
`timescale 1ns/10ps
module cxe_exception_entry_chk (
  input logic        clk,
  input logic        rstn,
  input logic        extResetPinN,
  input logic        wdtOverflow,
  input logic        trapExec,
  input logic [1:0]  trapNum,
  input logic        nmiReq,
  input logic        intMask,
  input logic        boundary,
  input logic        excBusy,
  input logic        coreReset,
  input logic        excStart,
  input logic [5:0]  excVector,
  input logic        excIsReset,
  input logic [15:0] irqAccept
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Boundary taken with no reset pending
  sequence s_take;
    boundary && !excBusy && !coreReset && extResetPinN && !wdtOverflow;
  endsequence
  a_start_one: assert property (excStart |=> !excStart)
    else $error("start pulse too long");
  a_pin_reset: assert property (!extResetPinN [*4] |-> coreReset)
    else $error("pin reset not held");
  a_wdt_reset: assert property (wdtOverflow [*4] |-> coreReset)
    else $error("wdt reset not held");
  a_reset_vec: assert property (excStart && excIsReset |->
    excVector == 6'h00 && !coreReset) else $error("bad reset entry");
  a_nmi_first: assert property (s_take ##0 nmiReq |=>
    excStart && excVector == 6'h07) else $error("nmi not first");
  a_trap_vec: assert property (s_take ##0 trapExec && !nmiReq |=>
    excVector == {4'h2, $past(trapNum)}) else $error("bad trap vector");
  a_mask_irq: assert property (s_take ##0 intMask |->
    ##2 irqAccept == 16'h0) else $error("masked irq taken");
  a_at_bound: assert property (excStart && !excIsReset |->
    $past(boundary) || $past(boundary, 2)) else $error("no boundary");
endmodule
bind cxe_exception_entry cxe_exception_entry_chk chk (.clk, .rstn,
  .extResetPinN, .wdtOverflow, .trapExec, .trapNum, .nmiReq, .intMask,
  .boundary, .excBusy, .coreReset, .excStart, .excVector, .excIsReset,
  .irqAccept);

// file: sim/cxe_exception_entry_tb.sv
// Self-checking bench for the exception entry block
`timescale 1ns/10ps
module cxe_exception_entry_tb;
  logic        clk, rstn, extResetPinN, wdtOverflow, trapExec;
  logic        nmiReq, breakReq, intMask;
  logic [1:0]  trapNum;
  logic [15:0] irqReq;
  wire         boundary, excAck, coreReset, excStart, excIsReset, excBusy;
  wire [5:0]   excVector;
  wire [15:0]  irqAccept;
  int          bad_count, check_count;
  cxe_exception_entry uut (.clk, .rstn, .extResetPinN, .wdtOverflow,
    .trapExec, .trapNum, .nmiReq, .breakReq, .irqReq, .intMask, .boundary,
    .excAck, .coreReset, .excStart, .excVector, .excIsReset, .excBusy,
    .irqAccept);
  cxe_core_model core (.clk, .rstn, .coreReset, .excStart, .excIsReset,
    .excBusy, .boundary, .excAck);
  // Clock
  always #2.5 clk = ~clk;
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Next entry, compared as reset flag and vector
  task automatic wait_start(logic [15:0] exp);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (excStart !== 1'h1 && n < 300);
    if (n >= 300) bad_count++;
    if (n >= 300) stop_test;
    chk("entry", exp, {9'h0, excIsReset, excVector});
  endtask
  task automatic t_prio;
    {nmiReq, trapExec, breakReq, trapNum, irqReq} = 21'h1E0008;
    wait_start(16'h0007);
    chk("busy", 16'h1, {15'h0, excBusy});
    nmiReq = 1'h0;
    wait_start(16'h000A);
    trapExec = 1'h0;
    wait_start(16'h000C);
    breakReq = 1'h0;
    wait_start(16'h0011);
    chk("accept", 16'h0008, irqAccept);
    irqReq = 16'h0;
  endtask
  task automatic t_trap;
    {intMask, trapExec} = 2'h3;
    for (int n = 0; n < 4; n++) begin
      trapNum = n[1:0];
      wait_start(16'h0008 + n[15:0]);
    end
    {intMask, trapExec} = 2'h0;
  endtask
  task automatic t_mask;
    {intMask, irqReq} = 17'h10020;
    repeat (40) begin
      tick(1);
      chk("start", 16'h0, {15'h0, excStart});
    end
    breakReq = 1'h1;
    wait_start(16'h000C);
    {breakReq, intMask} = 2'h0;
    wait_start(16'h0013);
    chk("accept", 16'h0020, irqAccept);
    irqReq = 16'h0;
  endtask
  task automatic t_wdt;
    wdtOverflow = 1'h1;
    tick(4);
    chk("coreReset", 16'h1, {15'h0, coreReset});
    {wdtOverflow, nmiReq} = 2'h1;
    wait_start(16'h0040);
    wait_start(16'h0007);
    nmiReq = 1'h0;
  endtask
  // Reset with the pin low, then the scenarios
  initial begin
    {clk, rstn, extResetPinN, wdtOverflow, trapExec, intMask} = 6'h0;
    {nmiReq, breakReq, trapNum, irqReq, bad_count, check_count} = 0;
    tick(6);
    rstn = 1'h1;
    tick(6);
    chk("coreReset", 16'h1, {15'h0, coreReset});
    extResetPinN = 1'h1;
    wait_start(16'h0040);
    t_prio;
    t_trap;
    t_mask;
    t_wdt;
    stop_test;
  end
endmodule
